// >>> rsp_defines.svh
//Operation
//R01 - eight selectable bit rates, one active
//R02 - factory bit rate is 57600 baud
//R03 - parity choice fixes seven or eight bits
//R04 - default format no parity, eight bits
//R05 - settings survive power loss, reset, preset; here nrst reloads the factory settings
//R06 - parallel or serial port, never both
//R07 - bus address 0 to 30, default 9
//R08 - five flow modes, XON/XOFF default
//R09 - XOFF 13H stops sending, XON 11H resumes
//R10 - DTR/DSR mode sends only while DSR
//R11 - drop DTR near 100 buffered characters
//R12 - RTS/CTS mode gates on CTS, drops RTS
//R13 - modem mode raises DTR, RTS when ready
//R14 - host paces itself when flow is off
//R15 - start, data, optional parity, one stop
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

// ------------------------------------------------------------
// clock, bit timing, flow control and address limits
// ------------------------------------------------------------
`define RSP_CLK_HZ       10000000
`define RSP_FRAME_BITS   4'ha
`define RSP_NEAR_FULL    8'h64
`define RSP_XOFF_CHAR    8'h13
`define RSP_XON_CHAR     8'h11
`define RSP_ADDR_MAX     5'h1e

// ------------------------------------------------------------
// factory settings
// ------------------------------------------------------------
`define RSP_DEF_BAUD     3'h6
`define RSP_DEF_ADDR     5'h09

`endif

// >>> rsp_host_model.sv
`timescale 1ns/1ps

module rsp_host_model
  import rsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic [15:0] div,
  output logic             rxd
);
  logic [9:0] frames[$]; // characters seen on the line
  logic [9:0] f;

  // ------------------------------
  // receive
  // ------------------------------
  // mid-bit sampling
  // falling edge keeps clear of the device's own update edge
  always
  begin
    @(negedge clk);
    if (txd === 1'b0)
    begin
      repeat (div / 2) @(negedge clk);
      for (int i = 0; i < 10; i++)
      begin
        f[i] = txd;
        if (i < 9)
          repeat (div) @(negedge clk);
      end
      frames.push_back(f);
    end
  end

  // ------------------------------
  // send
  // ------------------------------
  initial rxd = 1'b1;
  // whole paced frames
  // line goes back to mark after every frame, even one with a broken bit
  task automatic send(input logic [9:0] fr);
    for (int k = 0; k < 10; k++)
    begin
      rxd <= fr[k];
      repeat (div) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
endmodule // rsp_host_model

// >>> rsp_pkg.sv
package rsp_pkg;

  // baud code 0..7 = 1200,2400,4800,9600,19200,38400,57600,115200
  typedef logic [2:0] rsp_baud_t;

  typedef enum logic [1:0] {RSP_PAR_NONE, RSP_PAR_EVEN, RSP_PAR_ODD} rsp_par_e;
  typedef enum logic [2:0] {RSP_FLOW_NONE, RSP_FLOW_XON, RSP_FLOW_DTR, RSP_FLOW_RTS,
                            RSP_FLOW_MODEM} rsp_flow_e;
  typedef enum logic {RSP_IF_PARALLEL, RSP_IF_SERIAL} rsp_if_e;

  typedef struct packed {
    rsp_baud_t  baud;
    rsp_par_e   par;
    rsp_flow_e  flow;
    rsp_if_e    iface;
    logic [4:0] addr;
  } rsp_cfg_s;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } rsp_rx_s;

endpackage

// >>> rsp_top.sv
`timescale 1ns/1ps
`include "rsp_defines.svh"
module rsp_top
  import rsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cfg_we,
  input  rsp_cfg_s        cfg_wdata,
  output rsp_cfg_s        cfg_q,
  output logic            cfg_bad_q,
  output logic            ser_en_q,
  output logic            par_en_q,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready_q,
  output logic            txd_q,
  input  wire logic       rxd,
  output logic            rx_valid_q,
  output rsp_rx_s         rx_q,
  input  wire logic [7:0] rx_level,
  input  wire logic       dsr,
  input  wire logic       cts,
  output logic            dtr_q,
  output logic            rts_q
);
  typedef enum {RSP_IDLE, RSP_BUSY} rsp_st_e;
  // ------------------------------------------------------------
  // settings store
  // ------------------------------------------------------------
  // R05 survive resets
  // only a write or nrst changes these; nrst reloads the factory settings
  wire addr_ok = (cfg_wdata.addr <= `RSP_ADDR_MAX);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // R02 R04 R07 R08 factory settings
      cfg_q     <= '{`RSP_DEF_BAUD, RSP_PAR_NONE, RSP_FLOW_XON, RSP_IF_PARALLEL, `RSP_DEF_ADDR};
      cfg_bad_q <= 1'b0;
    end
    else
    begin
      cfg_bad_q <= cfg_we && !addr_ok;
      // R07 address range
      if (cfg_we && addr_ok)
        cfg_q <= cfg_wdata;
    end
  end
  // R06 one port enabled
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_en_q <= 1'b0;
      par_en_q <= 1'b1;
    end
    else
    begin
      ser_en_q <= (cfg_q.iface == RSP_IF_SERIAL);
      par_en_q <= (cfg_q.iface == RSP_IF_PARALLEL);
    end
  end
  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  // R01 eight rates
  localparam logic [15:0] DIV [8] = '{16'(`RSP_CLK_HZ / 1200), 16'(`RSP_CLK_HZ / 2400),
    16'(`RSP_CLK_HZ / 4800), 16'(`RSP_CLK_HZ / 9600), 16'(`RSP_CLK_HZ / 19200),
    16'(`RSP_CLK_HZ / 38400), 16'(`RSP_CLK_HZ / 57600), 16'(`RSP_CLK_HZ / 115200)};
  wire [15:0] div      = DIV[cfg_q.baud];
  wire        with_par = (cfg_q.par != RSP_PAR_NONE);
  // ------------------------------------------------------------
  // two-entry transmit buffer
  // ------------------------------------------------------------
  logic [7:0] buf_mem [2];
  logic       wr_ptr_q, rd_ptr_q;
  logic [1:0] cnt_q;
  logic       tx_go;
  wire        push = tx_valid && tx_ready_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      cnt_q      <= 2'h0;
      tx_ready_q <= 1'b0;
    end
    else
    begin
      wr_ptr_q   <= wr_ptr_q ^ push;
      rd_ptr_q   <= rd_ptr_q ^ tx_go;
      cnt_q      <= cnt_q + {1'b0, push} - {1'b0, tx_go};
      // ready is registered from the next count, so it never lags cnt_q; a pop frees room only next cycle
      tx_ready_q <= (cnt_q + {1'b0, push} - {1'b0, tx_go}) < 2'h2;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      buf_mem[wr_ptr_q] <= tx_data;
  end
  // ------------------------------------------------------------
  // transmit flow gate
  // ------------------------------------------------------------
  logic xon_q;
  // R09 software pacing
  wire xon_ok  = (cfg_q.flow != RSP_FLOW_XON) || xon_q;
  // R10 DSR gating
  wire dsr_ok  = !(cfg_q.flow == RSP_FLOW_DTR || cfg_q.flow == RSP_FLOW_MODEM) || dsr;
  // R12 CTS gating
  wire cts_ok  = !(cfg_q.flow == RSP_FLOW_RTS || cfg_q.flow == RSP_FLOW_MODEM) || cts;
  wire send_ok = ser_en_q && xon_ok && dsr_ok && cts_ok;
  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  rsp_st_e     tx_st_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  wire  [7:0]  head   = buf_mem[rd_ptr_q];
  wire         par_tx = (cfg_q.par == RSP_PAR_ODD) ^ (^head[6:0]);
  // R03 width by parity
  wire         bit8   = with_par ? par_tx : head[7];
  // a character already started always completes; the gate acts between characters
  assign tx_go = (tx_st_q == RSP_IDLE) && (cnt_q != 2'h0) && send_ok;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_st_q  <= RSP_IDLE;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 10'h3ff;
      txd_q    <= 1'b1;
    end
    else
    begin
      case (tx_st_q)
        RSP_IDLE:
        begin
          txd_q <= 1'b1;
          // R15 frame layout
          if (tx_go)
          begin
            tx_sh_q  <= {1'b1, bit8, head[6:0], 1'b0};
            tx_cnt_q <= 16'h0;
            tx_bit_q <= 4'h0;
            tx_st_q  <= RSP_BUSY;
          end
        end
        RSP_BUSY:
        begin
          txd_q <= tx_sh_q[0];
          if (tx_cnt_q == div - 16'h1)
          begin
            tx_cnt_q <= 16'h0;
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == `RSP_FRAME_BITS - 4'h1)
              tx_st_q <= RSP_IDLE;
          end
          else
            tx_cnt_q <= tx_cnt_q + 16'h1;
        end
        default: tx_st_q <= RSP_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  rsp_st_e     rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [9:0]  rx_sh_q;
  wire         rx_tick = (rx_cnt_q == 16'h0);
  wire         rx_last = (rx_st_q == RSP_BUSY) && rx_tick && (rx_bit_q == `RSP_FRAME_BITS - 4'h1);
  wire  [9:0]  frame   = {rxd, rx_sh_q[9:1]};
  wire         par_rx  = (cfg_q.par == RSP_PAR_ODD) ^ (^frame[7:1]);
  wire  [7:0]  rx_chr  = with_par ? {1'b0, frame[7:1]} : frame[8:1];
  wire         rx_bad  = !frame[9] || (with_par && (frame[8] != par_rx));
  wire         is_ctl  = (cfg_q.flow == RSP_FLOW_XON) && !rx_bad &&
                         (rx_chr == `RSP_XOFF_CHAR || rx_chr == `RSP_XON_CHAR);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_st_q    <= RSP_IDLE;
      rx_cnt_q   <= 16'h0;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 10'h0;
      rx_valid_q <= 1'b0;
      rx_q       <= '0;
    end
    else
    begin
      rx_valid_q <= rx_last && !is_ctl;
      if (rx_last)
        rx_q <= '{rx_bad, rx_chr};
      case (rx_st_q)
        RSP_IDLE:
          // first sample lands in mid-bit of the start bit
          if (ser_en_q && !rxd)
          begin
            rx_cnt_q <= {1'b0, div[15:1]};
            rx_bit_q <= 4'h0;
            rx_st_q  <= RSP_BUSY;
          end
        RSP_BUSY:
          if (rx_tick)
          begin
            rx_sh_q  <= frame;
            rx_cnt_q <= div - 16'h1;
            rx_bit_q <= rx_bit_q + 4'h1;
            // a glitch shorter than half a bit is not a start
            if ((rx_bit_q == 4'h0 && rxd) || rx_last)
              rx_st_q <= RSP_IDLE;
          end
          else
            rx_cnt_q <= rx_cnt_q - 16'h1;
        default: rx_st_q <= RSP_IDLE;
      endcase
    end
  end

  // R09 pause and resume characters
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      xon_q <= 1'b1;
    else if (cfg_q.flow != RSP_FLOW_XON)
      xon_q <= 1'b1;
    else if (is_ctl && rx_last)
      xon_q <= (rx_chr == `RSP_XON_CHAR);
  end

  // ------------------------------------------------------------
  // modem control lines
  // ------------------------------------------------------------
  wire room = (rx_level < `RSP_NEAR_FULL);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
    end
    else
    begin
      // R11 R13 while the serial port is enabled, DTR follows buffer room in DTR mode and stays up in every other mode
      dtr_q <= ser_en_q && ((cfg_q.flow == RSP_FLOW_DTR) ? room : 1'b1);
      // R12 R13 RTS drops near full
      rts_q <= ser_en_q && ((cfg_q.flow == RSP_FLOW_RTS || cfg_q.flow == RSP_FLOW_MODEM) ? room : 1'b1);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_start;
    tx_go;
  endsequence
  sequence s_start_bit;
    ##1 !txd_q;
  endsequence

  a_frame_start: assert property (@(posedge clk) disable iff (!nrst) s_start |-> ##1 s_start_bit) // R15
    else $error("start bit missing after character start");
  a_ports_excl: assert property (@(posedge clk) disable iff (!nrst) ser_en_q != par_en_q) // R06
    else $error("both or neither port enabled");
  a_addr_range: assert property (@(posedge clk) disable iff (!nrst) cfg_q.addr <= `RSP_ADDR_MAX) // R07
    else $error("bus address out of range");
  a_addr_reject: assert property (@(posedge clk) disable iff (!nrst)
    cfg_we && !addr_ok |=> $stable(cfg_q) && cfg_bad_q) // R07
    else $error("bad address write accepted");
  a_dsr_gate: assert property (@(posedge clk) disable iff (!nrst)
    tx_go && cfg_q.flow == RSP_FLOW_DTR |-> dsr) // R10
    else $error("character started without DSR");
  a_cts_gate: assert property (@(posedge clk) disable iff (!nrst)
    tx_go && (cfg_q.flow == RSP_FLOW_RTS || cfg_q.flow == RSP_FLOW_MODEM) |-> cts) // R12
    else $error("character started without CTS");
  a_xoff_hold: assert property (@(posedge clk) disable iff (!nrst)
    tx_go && cfg_q.flow == RSP_FLOW_XON |-> xon_q) // R09
    else $error("character started while paused");
  a_dtr_full: assert property (@(posedge clk) disable iff (!nrst)
    ser_en_q && cfg_q.flow == RSP_FLOW_DTR && !room && $stable(cfg_q) |=> !dtr_q) // R11
    else $error("DTR held with buffer near full");
  a_modem_dtr: assert property (@(posedge clk) disable iff (!nrst)
    ser_en_q && cfg_q.flow == RSP_FLOW_MODEM && $stable(cfg_q) |=> dtr_q) // R13
    else $error("DTR low in modem mode");
  a_idle_line: assert property (@(posedge clk) disable iff (!nrst)
    tx_st_q == RSP_IDLE && !tx_go |=> txd_q) // R15
    else $error("line not marking while idle");

endmodule // rsp_top

// >>> rsp_top_tb.sv
`timescale 1ns/1ps

module rsp_top_tb
  import rsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst, cfg_we, cfg_bad_q, ser_en_q, par_en_q, tx_valid, tx_ready_q;
  logic        txd_q, rxd, rx_valid_q, dsr, cts, dtr_q, rts_q, bad_seen;
  logic [7:0]  tx_data, rx_level;
  logic [15:0] div;
  logic [9:0]  fr;
  rsp_cfg_s    cfg_wdata, cfg_q;
  rsp_rx_s     rx_q;
  rsp_rx_s     rxs[$];
  int          miscompares = 0;
  int          compares = 0;
  int          rates[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};

  always #50 clk = ~clk;

  rsp_top rsp_top_inst (.clk(clk), .nrst(nrst), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_q(cfg_q),
    .cfg_bad_q(cfg_bad_q), .ser_en_q(ser_en_q), .par_en_q(par_en_q), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready_q(tx_ready_q), .txd_q(txd_q), .rxd(rxd), .rx_valid_q(rx_valid_q), .rx_q(rx_q),
    .rx_level(rx_level), .dsr(dsr), .cts(cts), .dtr_q(dtr_q), .rts_q(rts_q));
  rsp_host_model rsp_host_model_inst (.clk(clk), .txd(txd_q), .div(div), .rxd(rxd));

  // ------------------------------
  // access tasks
  // ------------------------------
  // the valid pulse lasts one cycle, so catch it between edges
  always @(negedge clk)
    if (rx_valid_q === 1'b1)
      rxs.push_back(rx_q);

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cfg(input rsp_baud_t b, input rsp_par_e p, input rsp_flow_e f, input rsp_if_e i, input logic [4:0] a);
    cfg_we    <= 1'b1;
    cfg_wdata <= '{b, p, f, i, a};
    div        = 16'(10000000 / rates[b]);
    @(posedge clk);
    cfg_we <= 1'b0;
    @(negedge clk);
    bad_seen = cfg_bad_q;
    repeat (3) @(posedge clk);
  endtask

  task ser(input rsp_flow_e f);
    cfg(3'h7, RSP_PAR_NONE, f, RSP_IF_SERIAL, 5'h1e);
  endtask

  // ready is looked at between edges so the taking edge is never raced
  task push(input logic [7:0] d);
    tx_valid <= 1'b1;
    tx_data  <= d;
    do
      @(negedge clk);
    while (tx_ready_q !== 1'b1);
    @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task expect_frame(input logic [9:0] e);
    int n;
    n = 0;
    while (rsp_host_model_inst.frames.size() == 0 && n < 30000)
    begin
      @(posedge clk);
      n++;
    end
    fr = (rsp_host_model_inst.frames.size() > 0) ? rsp_host_model_inst.frames.pop_front() : 10'hx;
    chk(16'(fr), 16'(e));
    // let the stop bit run out so a rate change never lands mid-character
    repeat (div) @(posedge clk);
  endtask

  task tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, about one and a half times the expected run
  initial
  begin
    #9000000;
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    {nrst, cfg_we, tx_valid, dsr, cts} = '0;
    cfg_wdata = '0;
    tx_data   = '0;
    rx_level  = '0;
    div       = 16'd173;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(16'(cfg_q), 16'({3'h6, RSP_PAR_NONE, RSP_FLOW_XON, RSP_IF_PARALLEL, 5'h09}));
    chk(16'({par_en_q, ser_en_q, dtr_q, rts_q}), 16'h8);
    cfg(3'h7, RSP_PAR_NONE, RSP_FLOW_XON, RSP_IF_PARALLEL, 5'h1f);
    chk(16'({bad_seen, cfg_q.addr}), 16'h29);
    ser(RSP_FLOW_NONE);
    chk(16'({bad_seen, cfg_q.addr, par_en_q, ser_en_q, dtr_q, rts_q}), 16'h1e7);
    // slow rates below 4800 would dominate the run time
    for (int b = 2; b < 8; b++)
    begin
      cfg(rsp_baud_t'(b), RSP_PAR_NONE, RSP_FLOW_NONE, RSP_IF_SERIAL, 5'h1e);
      push(8'h30 + 8'(b));
      expect_frame({1'b1, 8'h30 + 8'(b), 1'b0});
    end
    for (int p = 0; p < 3; p++)
    begin
      cfg(3'h7, rsp_par_e'(p), RSP_FLOW_NONE, RSP_IF_SERIAL, 5'h1e);
      push(8'hd3);
      expect_frame({1'b1, p == 0 ? 1'b1 : (^7'h53) ^ (p == 2), 7'h53, 1'b0});
    end
    // flow control stays on while the host talks at full rate
    ser(RSP_FLOW_XON);
    rsp_host_model_inst.send({1'b1, 8'h3c, 1'b0});
    cfg(3'h7, RSP_PAR_EVEN, RSP_FLOW_XON, RSP_IF_SERIAL, 5'h1e);
    rsp_host_model_inst.send({1'b1, 1'b1, 7'h53, 1'b0});
    repeat (200) @(posedge clk);
    chk(16'(rxs.size()), 16'd2);
    chk(16'(rxs.pop_front()), 16'h003c);
    chk(16'(rxs.pop_front()), 16'h0153);
    ser(RSP_FLOW_XON);
    rsp_host_model_inst.send({1'b1, 8'h13, 1'b0});
    push(8'h41);
    repeat (2000) @(posedge clk);
    chk(16'(rsp_host_model_inst.frames.size() + rxs.size()), 16'd0);
    rsp_host_model_inst.send({1'b1, 8'h11, 1'b0});
    expect_frame({1'b1, 8'h41, 1'b0});
    chk(16'(rxs.size()), 16'd0);
    for (int m = 0; m < 5; m++)
      for (int l = 99; l < 101; l++)
      begin
        rx_level <= 8'(l);
        ser(rsp_flow_e'(m));
        if (m != 3)
          chk(16'(dtr_q), 16'(m != 2 || l < 100));
        if (m != 2)
          chk(16'(rts_q), 16'(m < 3 || l < 100));
      end
    rx_level <= 8'h00;
    // far side holds the gate shut while the buffer fills, then opens it
    for (int m = 2; m < 5; m++)
    begin
      dsr <= (m == 3);
      cts <= (m == 2);
      ser(rsp_flow_e'(m));
      push(8'h61);
      push(8'h62);
      repeat (1000) @(posedge clk);
      chk(16'(tx_ready_q), 16'd0);
      chk(16'(rsp_host_model_inst.frames.size()), 16'd0);
      dsr <= 1'b1;
      cts <= 1'b1;
      expect_frame({1'b1, 8'h61, 1'b0});
      expect_frame({1'b1, 8'h62, 1'b0});
      repeat (5) @(posedge clk);
      chk(16'(tx_ready_q), 16'd1);
    end
    chk(16'(cfg_q), 16'({3'h7, RSP_PAR_NONE, RSP_FLOW_MODEM, RSP_IF_SERIAL, 5'h1e}));
    tally_and_finish();
  end
endmodule // rsp_top_tb
